// file: shared/rmsc_pkg.sv
package rmsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Channel layout: index 0 voltage, 1 current A, 2 current B.
   localparam int CHANNELS = 3;
   localparam int SAMPLE_W = 24;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (register index on the register port).
   localparam logic [15:0] ACC_LO_OFS  [CHANNELS] = '{16'h2003, 16'h2006, 16'h2008};
   localparam logic [15:0] ACC_HI_OFS  [CHANNELS] = '{16'h2004, 16'h2007, 16'h2009};
   localparam logic [15:0] OFF_LO_OFS  [CHANNELS] = '{16'h200b, 16'h200d, 16'h2010};
   localparam logic [15:0] OFF_HI_OFS  [CHANNELS] = '{16'h200c, 16'h200e, 16'h2011};
   localparam logic [15:0] INST_OFS    [CHANNELS] = '{16'h2100, 16'h2101, 16'h2102};
   localparam logic [15:0] AVG_OFS     [CHANNELS] = '{16'h2104, 16'h2105, 16'h2106};
   localparam logic [15:0] GAIN_OFS    [CHANNELS] = '{16'h2108, 16'h2109, 16'h210a};
   localparam logic [15:0] BPF_COEF_OFS = 16'h20ef;
   localparam logic [15:0] CTRL_ONE_OFS = 16'h2878;
   localparam logic [15:0] CTRL_THR_OFS = 16'h287a;
   localparam logic [15:0] DET_CTRL_OFS = 16'h2886;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions.
   localparam int CALC_EN_BIT = 4;
   localparam int BPF_EN_BIT  = 6;
   localparam int GATE_BIT    = 7;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values.
   localparam logic [7:0]  CTRL_ONE_RST = 8'h00;
   localparam logic [7:0]  CTRL_THR_RST = 8'h00;
   localparam logic        GATE_RST     = 1'b0;
   localparam logic [31:0] BPF_COEF_RST = 32'h0000_0000;
   localparam logic [31:0] LOW_CLK_COEF = 32'h911d_3c9c;
   localparam logic [31:0] GAIN_RST     = 32'h0000_0000;
   localparam logic [63:0] OFFSET_RST   = 64'h0;
   localparam logic [31:0] RMS_RST      = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Filter and root timing counts.
   localparam int HPF_SHIFT  = 10;
   localparam int LPF_SHIFT  = 8;
   localparam int AVG_SHIFT  = 4;
   localparam int ROOT_STEPS = 32;

endpackage

// file: shared/rmsc_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rmsc_if;
   import rmsc_pkg::*;

   // Decimated sample stream.
   logic                       sample_valid;
   logic signed [SAMPLE_W-1:0] sample [CHANNELS];
   // Register port.
   logic                       reg_wr;
   logic                       reg_rd;
   logic [15:0]                reg_addr;
   logic [31:0]                reg_wdata;
   logic [31:0]                reg_rdata;
   logic                       reg_rvalid;

   modport dev (input sample_valid, sample, reg_wr, reg_rd, reg_addr, reg_wdata,
                output reg_rdata, reg_rvalid);
   modport src (output sample_valid, sample, reg_wr, reg_rd, reg_addr, reg_wdata,
                input reg_rdata, reg_rvalid);
endinterface // rmsc_if
`default_nettype wire

// file: rtl/rmsc_channel.sv
`timescale 1ns/10ps
`default_nettype none
module rmsc_channel #(
   parameter int W  = 24,
   parameter int HS = 10,
   parameter int LS = 8,
   parameter int AS = 4
) (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst_n,
   input  wire logic                ce,
   // Control
   input  wire logic                run,
   input  wire logic                bpf_en,
   input  wire logic [31:0]         coef,
   input  wire logic [31:0]         gain,
   input  wire logic [63:0]         offset,
   // Samples
   input  wire logic                sample_valid,
   input  wire logic signed [W-1:0] sample,
   // Results
   output logic [63:0]              square_acc,
   output logic [31:0]              inst_rms,
   output logic [31:0]              avg_rms
);
   import rmsc_pkg::*;

   logic signed [W+HS-1:0] dc_acc;
   logic signed [W:0]      hp_prev;
   logic signed [W:0]      bp_y;
   logic [63:0]            target;
   logic [31:0]            root;
   logic [4:0]             idx;
   logic                   busy;
   logic [31:0]            raw_rms;
   logic                   fire;
   logic                   fire_avg;

   wire                    step = ce & run;
   wire                    take = step & sample_valid;
   wire signed [W+HS-1:0]  dc_mean = dc_acc >>> HS;
   wire signed [W:0]       hp = {sample[W-1], sample} - dc_mean[W:0];
   wire signed [W+32:0]    fb = bp_y * $signed(coef);
   wire signed [W:0]       bp = hp - hp_prev + $signed(fb[W+31:31]);
   wire signed [W:0]       filt = bpf_en ? bp : hp;
   wire signed [2*W+1:0]   sq = filt * filt;
   wire [63:0]             sq64 = {{(62-2*W){1'b0}}, sq};
   wire signed [63:0]      ms_diff = sq64 - square_acc;
   wire signed [63:0]      ms_step = ms_diff >>> LS;
   wire [63:0]             corrected = (square_acc > offset) ? square_acc - offset : 64'h0;
   wire [31:0]             trial = root | (32'h1 << idx);
   wire [63:0]             trial_sq = trial * trial;
   wire [31:0]             next_root = (trial_sq <= target) ? trial : root;
   wire signed [64:0]      gprod = $signed({1'b0, raw_rms}) * $signed(gain);
   wire signed [33:0]      gsum = $signed({2'b00, raw_rms}) + $signed(gprod[64:31]);
   wire [31:0]             gsat = gsum[33] ? 32'h0 : (|gsum[32:31]) ? 32'h7fff_ffff : gsum[31:0];
   wire signed [32:0]      adiff = $signed({inst_rms[31], inst_rms}) - $signed({avg_rms[31], avg_rms});
   wire signed [32:0]      astep = adiff >>> AS;

   ////////////////////////////////////////////////////////////////////////////
   // DC removal, optional band-pass and mean-square low-pass.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dc_acc     <= '0;
         hp_prev    <= '0;
         bp_y       <= '0;
         square_acc <= OFFSET_RST;
      end else if (take) begin
         dc_acc     <= dc_acc + {{(HS-1){hp[W]}}, hp};
         hp_prev    <= hp;
         bp_y       <= bp;
         square_acc <= square_acc + ms_step;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bit-serial square root of the corrected mean square.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         target  <= '0;
         root    <= '0;
         idx     <= '0;
         busy    <= 1'b0;
         raw_rms <= '0;
         fire    <= 1'b0;
      end else if (step) begin
         fire <= 1'b0;
         if (!busy && sample_valid) begin
            target <= corrected;
            root   <= '0;
            idx    <= 5'(ROOT_STEPS - 1);
            busy   <= 1'b1;
         end else if (busy) begin
            root <= next_root;
            idx  <= idx - 5'h1;
            if (idx == 5'h0) begin
               busy    <= 1'b0;
               raw_rms <= next_root;
               fire    <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gain calibration and averaging.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         inst_rms <= RMS_RST;
         avg_rms  <= RMS_RST;
         fire_avg <= 1'b0;
      end else if (step) begin
         fire_avg <= fire;
         if (fire)
            inst_rms <= gsat;
         if (fire_avg)
            avg_rms <= avg_rms + astep[31:0];
      end
   end

endmodule // rmsc_channel
`default_nettype wire

// file: rtl/rmsc_device.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - Control one bit 4 enables calculation
// - Gate bit 7 stops sampling and calculation
// - Energy accumulation keeps running while gated
// - Software programs pulse threshold before gating
// - Control three bit 6 inserts band-pass
// - Band-pass coefficient register at 0x20ef
// - Before slow clock, disable then write coefficient
// - Back at fast clock, restore default coefficient
// - Square each sample, then low-pass filter
// - Square root gives 32-bit raw value
// - Instantaneous value is raw times one plus gain
// - Average instantaneous values into average register
// - Readable 64-bit squared data per channel
// - Writable 64-bit offset pair per channel
// - Software copies grounded squared data to offset
// - Results read as 32-bit two's complement
// - Any reset source clears result registers
// - Sine result is amplitude times root-two half
// - Input passes a DC-removing filter, never bypassed
module rmsc_device #(
   parameter int SAMPLE_W = rmsc_pkg::SAMPLE_W
) (
   // Clock and resets
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic external_reset_pin_n,
   input  wire logic watchdog_reset_n,
   input  wire logic ce,
   // Link to sample source and processor
   rmsc_if.dev       link,
   // Status
   output logic      calc_running,
   output logic      energy_accum_run
);
   import rmsc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Reset merge and control state.
   wire         rst_n = reset_n & external_reset_pin_n & watchdog_reset_n;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage and channel results.
   logic [7:0]  ctrl_one;
   logic [7:0]  ctrl_thr;
   logic        sampling_gate;
   logic [31:0] bandpass_coefficient;
   logic [31:0] gain      [CHANNELS];
   logic [63:0] offset    [CHANNELS];
   logic [63:0] sq_acc    [CHANNELS];
   logic [31:0] inst_rms  [CHANNELS];
   logic [31:0] avg_rms   [CHANNELS];
   logic [31:0] ch_rdata  [CHANNELS];

   ////////////////////////////////////////////////////////////////////////////
   // Calculation enable and band-pass select.
   wire         power_rms_calc_enable  = ctrl_one[CALC_EN_BIT];
   wire         bandpass_filter_enable = ctrl_thr[BPF_EN_BIT];
   wire         run = power_rms_calc_enable & ~sampling_gate;

   ////////////////////////////////////////////////////////////////////////////
   // Control register decode.
   wire         hit_one  = link.reg_addr == CTRL_ONE_OFS;
   wire         hit_thr  = link.reg_addr == CTRL_THR_OFS;
   wire         hit_det  = link.reg_addr == DET_CTRL_OFS;
   wire         hit_coef = link.reg_addr == BPF_COEF_OFS;
   wire         wr_en    = link.reg_wr & ce;
   wire         wr_one   = wr_en & hit_one;
   wire         wr_thr   = wr_en & hit_thr;
   wire         wr_det   = wr_en & hit_det;
   wire         wr_coef  = wr_en & hit_coef;

   wire [31:0]  one_word = {24'h0, ctrl_one};
   wire [31:0]  thr_word = {24'h0, ctrl_thr};
   wire [31:0]  det_word = {24'h0, sampling_gate, 7'h0};

   wire [31:0]  ctrl_rdata = hit_one  ? one_word :
                             hit_thr  ? thr_word :
                             hit_det  ? det_word :
                             hit_coef ? bandpass_coefficient :
                                        32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Read data: unselected sources give zero, so the words are ORed.
   wire [31:0]  read_value = ctrl_rdata | ch_rdata[0] | ch_rdata[1] | ch_rdata[2];

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_one <= CTRL_ONE_RST;
         ctrl_thr <= CTRL_THR_RST;
      end else begin
         if (wr_one)
            ctrl_one <= link.reg_wdata[7:0];
         if (wr_thr)
            ctrl_thr <= link.reg_wdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sampling gate and band-pass coefficient.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sampling_gate        <= GATE_RST;
         bandpass_coefficient <= BPF_COEF_RST;
      end else begin
         if (wr_det)
            sampling_gate <= link.reg_wdata[GATE_BIT];
         if (wr_coef)
            bandpass_coefficient <= link.reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-channel registers and datapath.
   for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
      wire hit_acc_lo = link.reg_addr == ACC_LO_OFS[g];
      wire hit_acc_hi = link.reg_addr == ACC_HI_OFS[g];
      wire hit_off_lo = link.reg_addr == OFF_LO_OFS[g];
      wire hit_off_hi = link.reg_addr == OFF_HI_OFS[g];
      wire hit_inst   = link.reg_addr == INST_OFS[g];
      wire hit_avg    = link.reg_addr == AVG_OFS[g];
      wire hit_gain   = link.reg_addr == GAIN_OFS[g];
      wire wr_off_lo  = wr_en & hit_off_lo;
      wire wr_off_hi  = wr_en & hit_off_hi;
      wire wr_gain    = wr_en & hit_gain;

      // Read selection for this channel.
      assign ch_rdata[g] = hit_acc_lo ? sq_acc[g][31:0] :
                           hit_acc_hi ? sq_acc[g][63:32] :
                           hit_off_lo ? offset[g][31:0] :
                           hit_off_hi ? offset[g][63:32] :
                           hit_inst   ? inst_rms[g] :
                           hit_avg    ? avg_rms[g] :
                           hit_gain   ? gain[g] :
                                        32'h0;

      // Offset and gain calibration registers.
      always_ff @(posedge clock or negedge rst_n) begin
         if (!rst_n) begin
            offset[g] <= OFFSET_RST;
            gain[g]   <= GAIN_RST;
         end else begin
            if (wr_off_lo)
               offset[g][31:0] <= link.reg_wdata;
            if (wr_off_hi)
               offset[g][63:32] <= link.reg_wdata;
            if (wr_gain)
               gain[g] <= link.reg_wdata;
         end
      end

      // Datapath of one channel.
      rmsc_channel #(
         .W  (SAMPLE_W),
         .HS (HPF_SHIFT),
         .LS (LPF_SHIFT),
         .AS (AVG_SHIFT)
      ) u_channel (
         .clock        (clock),
         .rst_n        (rst_n),
         .ce           (ce),
         .run          (run),
         .bpf_en       (bandpass_filter_enable),
         .coef         (bandpass_coefficient),
         .gain         (gain[g]),
         .offset       (offset[g]),
         .sample_valid (link.sample_valid),
         .sample       (link.sample[g]),
         .square_acc   (sq_acc[g]),
         .inst_rms     (inst_rms[g]),
         .avg_rms      (avg_rms[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read response, one cycle after the read strobe.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         link.reg_rdata  <= 32'h0;
         link.reg_rvalid <= 1'b0;
      end else if (ce) begin
         link.reg_rvalid <= link.reg_rd;
         if (link.reg_rd)
            link.reg_rdata <= read_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status outputs.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         calc_running     <= 1'b0;
         energy_accum_run <= 1'b0;
      end else if (ce) begin
         calc_running     <= run;
         energy_accum_run <= 1'b1;
      end
   end

endmodule // rmsc_device
`default_nettype wire

// file: rtl/rmsc_host.sv
`timescale 1ns/10ps
`default_nettype none
module rmsc_host (
   // Clock and reset
   input  wire logic                                clock,
   input  wire logic                                reset_n,
   input  wire logic                                ce,
   // Decimated samples
   input  wire logic                                sample_valid_in,
   input  wire logic signed [rmsc_pkg::SAMPLE_W-1:0] sample_in [rmsc_pkg::CHANNELS],
   // Command port
   input  wire logic                                cmd_valid,
   input  wire logic                                cmd_write,
   input  wire logic [15:0]                         cmd_addr,
   input  wire logic [31:0]                         cmd_wdata,
   output logic                                     cmd_ready,
   output logic                                     rsp_valid,
   output logic [31:0]                              rsp_data,
   // Sequences
   input  wire logic                                threshold_set,
   input  wire logic                                slow_clock_req,
   input  wire logic                                fast_clock_req,
   input  wire logic                                cal_req,
   input  wire logic [1:0]                          cal_channel,
   output logic                                     energy_disable,
   // Link to device
   rmsc_if.src                                      link
);
   import rmsc_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE  = 3'b000,
      H_RWAIT = 3'b001,
      H_CRLO  = 3'b010,
      H_CRHI  = 3'b011,
      H_CWHI  = 3'b100,
      H_SLOW  = 3'b101,
      H_FAST  = 3'b110
   } rmsc_hstate_t;

   rmsc_hstate_t state;
   logic [1:0]   ch;
   logic [31:0]  cal_lo;

   wire cal_ok   = cal_req & (cal_channel < 2'(CHANNELS));
   wire seq_any  = cal_ok | slow_clock_req | fast_clock_req;
   wire idle     = state == H_IDLE;
   wire take_cmd = idle & cmd_valid & cmd_ready & ~seq_any;
   wire gate_bad = (cmd_addr == DET_CTRL_OFS) & ~threshold_set;
   wire [31:0] cmd_data = gate_bad ? (cmd_wdata & ~(32'h1 << GATE_BIT)) : cmd_wdata;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         link.sample_valid <= 1'b0;
         for (int i = 0; i < CHANNELS; i++)
            link.sample[i] <= '0;
      end else if (ce) begin
         link.sample_valid <= sample_valid_in;
         for (int i = 0; i < CHANNELS; i++)
            link.sample[i] <= sample_in[i];
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state <= H_IDLE;
         ch <= 2'h0;
         cal_lo <= 32'h0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 32'h0;
         energy_disable <= 1'b0;
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         link.reg_addr <= 16'h0;
         link.reg_wdata <= 32'h0;
      end else if (ce) begin
         link.reg_wr <= 1'b0;
         link.reg_rd <= 1'b0;
         rsp_valid <= 1'b0;
         cmd_ready <= 1'b0;
         case (state)
            H_IDLE: begin
               cmd_ready <= 1'b1;
               if (cal_ok) begin
                  ch <= cal_channel;
                  link.reg_rd <= 1'b1;
                  link.reg_addr <= ACC_LO_OFS[cal_channel];
                  cmd_ready <= 1'b0;
                  state <= H_CRLO;
               end else if (slow_clock_req) begin
                  energy_disable <= 1'b1;
                  cmd_ready <= 1'b0;
                  state <= H_SLOW;
               end else if (fast_clock_req) begin
                  link.reg_wr <= 1'b1;
                  link.reg_addr <= BPF_COEF_OFS;
                  link.reg_wdata <= BPF_COEF_RST;
                  cmd_ready <= 1'b0;
                  state <= H_FAST;
               end else if (take_cmd) begin
                  link.reg_wr <= cmd_write;
                  link.reg_rd <= ~cmd_write;
                  link.reg_addr <= cmd_addr;
                  link.reg_wdata <= cmd_data;
                  cmd_ready <= 1'b0;
                  state <= cmd_write ? H_FAST : H_RWAIT;
               end
            end
            H_RWAIT: begin
               if (link.reg_rvalid) begin
                  rsp_valid <= 1'b1;
                  rsp_data <= link.reg_rdata;
                  cmd_ready <= 1'b1;
                  state <= H_IDLE;
               end
            end
            H_CRLO: begin
               if (link.reg_rvalid) begin
                  cal_lo <= link.reg_rdata;
                  link.reg_rd <= 1'b1;
                  link.reg_addr <= ACC_HI_OFS[ch];
                  state <= H_CRHI;
               end
            end
            H_CRHI: begin
               if (link.reg_rvalid) begin
                  link.reg_wr <= 1'b1;
                  link.reg_addr <= OFF_LO_OFS[ch];
                  link.reg_wdata <= cal_lo;
                  cal_lo <= link.reg_rdata;
                  state <= H_CWHI;
               end
            end
            H_CWHI: begin
               link.reg_wr <= 1'b1;
               link.reg_addr <= OFF_HI_OFS[ch];
               link.reg_wdata <= cal_lo;
               state <= H_FAST;
            end
            H_SLOW: begin
               link.reg_wr <= 1'b1;
               link.reg_addr <= BPF_COEF_OFS;
               link.reg_wdata <= LOW_CLK_COEF;
               state <= H_FAST;
            end
            H_FAST: begin
               if (link.reg_addr == BPF_COEF_OFS && link.reg_wdata == BPF_COEF_RST)
                  energy_disable <= 1'b0;
               cmd_ready <= 1'b1;
               state <= H_IDLE;
            end
            default: state <= H_IDLE;
         endcase
      end
   end

endmodule // rmsc_host
`default_nettype wire

// file: sim/rmsc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rmsc_assertions (
   // Clock and reset
   input wire logic        clock,
   input wire logic        reset_n,
   // Register port
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_rvalid
);
   import rmsc_pkg::*;
   logic [31:0] last_off;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) last_off <= OFFSET_RST[31:0];
      else if (reg_wr && reg_addr == OFF_LO_OFS[0]) last_off <= reg_wdata;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_rd; reg_rd |=> reg_rvalid; endproperty
   a_rd: assert property (p_rd) else $error("read not answered");
   property p_rv; reg_rvalid |-> $past(reg_rd); endproperty
   a_rv: assert property (p_rv) else $error("answer without read");
   property p_hold; !reg_rvalid |-> $stable(reg_rdata); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_unmap; reg_rd && reg_addr == 16'h2005 |=> reg_rdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_det; reg_rd && reg_addr == DET_CTRL_OFS |=> {reg_rdata[31:8], reg_rdata[6:0]} == 31'h0; endproperty
   a_det: assert property (p_det) else $error("gate read bad");
   property p_ctl; reg_rd && reg_addr == CTRL_ONE_OFS |=> reg_rdata[31:8] == 24'h0; endproperty
   a_ctl: assert property (p_ctl) else $error("control read bad");
   property p_off; reg_rd && reg_addr == OFF_LO_OFS[0] |=> reg_rdata == $past(last_off); endproperty
   a_off: assert property (p_off) else $error("offset readback bad");
   property p_cal;
      reg_rd && reg_addr == ACC_LO_OFS[0] |=> reg_rvalid ##1 reg_rd && reg_addr == ACC_HI_OFS[0] ##1 reg_rvalid
         ##1 reg_wr && reg_addr == OFF_LO_OFS[0] && reg_wdata == $past(reg_rdata, 2)
         ##1 reg_wr && reg_addr == OFF_HI_OFS[0] && reg_wdata == reg_rdata;
   endproperty
   a_cal: assert property (p_cal) else $error("calibration copy bad");
   property p_coef;
      reg_wr && reg_addr == BPF_COEF_OFS |-> reg_wdata == LOW_CLK_COEF || reg_wdata == BPF_COEF_RST;
   endproperty
   a_coef: assert property (p_coef) else $error("coefficient bad");
endmodule // rmsc_assertions
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   import rmsc_pkg::*;
   logic clock = 0, reset_n = 0, ext_n = 1, wd = 1, sv = 0, cv = 0, cw = 0;
   logic thr = 0, slow = 0, fast = 0, cal = 0, cmd_ready, rsp_valid, edis, crun, erun;
   logic [15:0] ca = 0;
   logic [31:0] cd = 0, rd, rsp_data;
   logic [1:0] cal_ch = 0;
   logic signed [SAMPLE_W-1:0] smp [CHANNELS] = '{24'sh10_0000, 24'sh08_0000, 24'sh04_0000};
   int n_mismatch = 0, checked = 0;
   always #2 clock = ~clock;
   rmsc_if lnk ();
   rmsc_host rmsc_host_i (.clock, .reset_n, .ce(1'b1), .sample_valid_in(sv), .sample_in(smp),
      .cmd_valid(cv), .cmd_write(cw), .cmd_addr(ca), .cmd_wdata(cd), .cmd_ready, .rsp_valid, .rsp_data,
      .threshold_set(thr), .slow_clock_req(slow), .fast_clock_req(fast), .cal_req(cal), .cal_channel(cal_ch),
      .energy_disable(edis), .link(lnk.src));
   rmsc_device rmsc_device_i (.clock, .reset_n, .external_reset_pin_n(ext_n), .watchdog_reset_n(wd),
      .ce(1'b1), .link(lnk.dev), .calc_running(crun), .energy_accum_run(erun));
   rmsc_assertions rmsc_assertions_i (.clock, .reset_n(reset_n & ext_n & wd), .reg_wr(lnk.reg_wr),
      .reg_rd(lnk.reg_rd),
      .reg_addr(lnk.reg_addr), .reg_wdata(lnk.reg_wdata), .reg_rdata(lnk.reg_rdata), .reg_rvalid(lnk.reg_rvalid));
   task automatic stop_test;
      $display("checked %0d n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic cmd(logic w, logic [15:0] a, logic [31:0] d);
      @(negedge clock);
      for (int i = 0; i < 20 && cmd_ready !== 1'b1; i++) @(negedge clock);
      {cw, ca, cd, cv} = {w, a, d, 1'b1};
      @(negedge clock);
      cv = 0;
      for (int i = 0; i < 8 && rsp_valid !== 1'b1 && !w; i++) @(negedge clock);
      rd = rsp_data;
   endtask
   task automatic rchk(string nm, logic [15:0] a, logic [31:0] e);
      cmd(0, a, 0);
      chk(nm, e, rd);
   endtask
   task automatic pulse(ref logic s);
      @(negedge clock);
      s = 1;
      @(negedge clock);
      s = 0;
      repeat (8) @(negedge clock);
   endtask
   task automatic feed(int n);
      repeat (n) begin
         @(negedge clock);
         foreach (smp[i]) smp[i] = -smp[i];
         sv = 1;
         @(negedge clock);
         sv = 0;
      end
      repeat (40) @(negedge clock);
   endtask
   task automatic t_reset;
      rchk("ctrl_one", CTRL_ONE_OFS, {24'h0, CTRL_ONE_RST});
      rchk("ctrl_three", CTRL_THR_OFS, {24'h0, CTRL_THR_RST});
      rchk("coef", BPF_COEF_OFS, BPF_COEF_RST);
      for (int i = 0; i < CHANNELS; i++) rchk("avg", AVG_OFS[i], RMS_RST);
   endtask
   task automatic t_regs;
      cmd(1, CTRL_THR_OFS, 32'h40);
      rchk("bpf_en", CTRL_THR_OFS, 32'h40);
      cmd(1, OFF_LO_OFS[0], 32'h1234_5678);
      rchk("off_lo", OFF_LO_OFS[0], 32'h1234_5678);
      cmd(1, OFF_HI_OFS[2], 32'h0bad_cafe);
      rchk("off_hi", OFF_HI_OFS[2], 32'h0bad_cafe);
      cmd(1, ACC_HI_OFS[1], 32'hffff_ffff);
      rchk("acc_ro", ACC_HI_OFS[1], 32'h0);
   endtask
   task automatic t_gate;
      cmd(1, DET_CTRL_OFS, 32'h80);
      rchk("gate_early", DET_CTRL_OFS, 32'h0);
      thr = 1;
      cmd(1, DET_CTRL_OFS, 32'h80);
      rchk("gate", DET_CTRL_OFS, 32'h80);
      cmd(1, CTRL_ONE_OFS, 32'h10);
      feed(20);
      chk("run_gated", 32'h0, {31'h0, crun});
      chk("energy_run", 32'h1, {31'h0, erun});
      rchk("frozen", INST_OFS[0], RMS_RST);
      cmd(1, DET_CTRL_OFS, 32'h0);
      repeat (4) @(negedge clock);
      chk("run", 32'h1, {31'h0, crun});
   endtask
   task automatic t_rms;
      cmd(1, GAIN_OFS[1], 32'h8000_0000);
      feed(600);
      cmd(0, ACC_HI_OFS[0], 0);
      chk("acc_v", 32'h1, {31'h0, rd != 32'h0});
      cmd(0, INST_OFS[0], 0);
      chk("inst_v", 32'h1, {31'h0, rd != 32'h0 && !rd[31]});
      cmd(0, AVG_OFS[0], 0);
      chk("avg_v", 32'h1, {31'h0, rd != 32'h0 && !rd[31]});
      rchk("inst_gain", INST_OFS[1], 32'h0);
      rchk("inst_off", INST_OFS[2], 32'h0);
   endtask
   task automatic t_seq;
      cmd(1, CTRL_ONE_OFS, 32'h0);
      pulse(slow);
      chk("edis_slow", 32'h1, {31'h0, edis});
      rchk("coef_slow", BPF_COEF_OFS, LOW_CLK_COEF);
      pulse(fast);
      chk("edis_fast", 32'h0, {31'h0, edis});
      rchk("coef_fast", BPF_COEF_OFS, BPF_COEF_RST);
      pulse(cal);
      cmd(0, ACC_HI_OFS[0], 0);
      rchk("cal_hi", OFF_HI_OFS[0], rd);
      rchk("unmapped", 16'h2005, 32'h0);
      ext_n = 0;
      @(negedge clock);
      ext_n = 1;
      rchk("pin_reset", INST_OFS[0], RMS_RST);
      cmd(1, CTRL_THR_OFS, 32'h40);
      @(negedge clock);
      wd = 0;
      @(negedge clock);
      wd = 1;
      rchk("wd_reset", CTRL_THR_OFS, {24'h0, CTRL_THR_RST});
   endtask
   initial begin
      repeat (20) @(negedge clock);
      reset_n = 1;
      t_reset;
      t_regs;
      t_gate;
      t_rms;
      t_seq;
      stop_test;
   end
   initial begin
      #40000;
      n_mismatch++;
      stop_test;
   end
endmodule // tb
`default_nettype wire
